// file: hw/udiv_pkg.sv
// constants shared by the unsigned 16/8 divide unit and its register file
// assumes a 32-bit axi4-lite bus with byte addresses 8 bits wide
package udiv_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_DIVIDEND = 8'h04;
  localparam logic [7:0] OFF_DIVISOR  = 8'h08;
  localparam logic [7:0] OFF_FLAGS    = 8'h0C;
  localparam logic [7:0] OFF_RESULT   = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  localparam logic [7:0] OFF_INT_STAT = 8'h18;
  localparam logic [7:0] OFF_INT_MASK = 8'h1C;
  // opcodes of the divide forms
  localparam logic [7:0] OPC_PAIR = 8'h94;
  localparam logic [7:0] OPC_PTR  = 8'h95;
  localparam logic [7:0] OPC_LIT  = 8'h96;
  // flag byte bit positions
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;
  // interrupt status bits
  localparam int INT_DONE = 0;
  localparam int INT_BAD  = 1;
  // status register bits
  localparam int STAT_BUSY   = 0;
  localparam int STAT_MODE_L = 2;
  // cycle counts
  localparam logic [4:0] CYC_ZERO = 5'h0A;
  localparam logic [4:0] CYC_FULL = 5'h1A;
  localparam logic [4:0] ITER_N   = 5'h10;
  // values after reset
  localparam logic [7:0]  RST_FLAGS  = 8'h00;
  localparam logic [15:0] RST_RESULT = 16'h0000;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    register_pair_mode,
    pointer_operand_mode,
    literal_operand_mode,
    udiv_no_mode
  } udiv_mode_e;
endpackage

// file: hw/udiv_if.sv
// carrier between the divide register file and the divide core
// assumes both ends share aclk
`timescale 1ns/1ns
`default_nettype none
interface udiv_if;
  logic        start;
  logic [15:0] dividend;
  logic [7:0]  divisor;
  logic        busy;
  logic        done;
  logic [7:0]  quot;
  logic [7:0]  rem;
  logic        fc;
  logic        fz;
  logic        fs;
  logic        fv;
  modport core (input start, dividend, divisor, output busy, done, quot, rem, fc, fz, fs, fv);
  modport ctrl (output start, dividend, divisor, input busy, done, quot, rem, fc, fz, fs, fv);
endinterface
`default_nettype wire

// file: hw/udiv_core.sv
// restoring 16 by 8 unsigned divider, one quotient bit per cycle
// assumes start is only raised while busy is low
`timescale 1ns/1ns
`default_nettype none
module udiv_core (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // operands and results
  udiv_if.core     dv
);
  typedef enum logic {ST_IDLE, ST_RUN} udiv_st_e;
  udiv_st_e    state_r;
  logic [4:0]  cnt_r;
  logic [4:0]  last_r;
  logic [15:0] q_r;
  logic [15:0] dvd_r;
  logic [7:0]  rem_r;
  logic [7:0]  dvs_r;
  logic [8:0]  sh;
  logic        take;
  logic        ovf;
  logic        done_r;
  logic [7:0]  quot_o_r;
  logic [7:0]  rem_o_r;
  logic        fc_r;
  logic        fz_r;
  logic        fs_r;
  logic        fv_r;

  // full 16-bit quotient kept so overflow range is known exactly
  always_comb begin
    sh   = {rem_r, q_r[15]};
    take = sh >= {1'b0, dvs_r};
    ovf  = (dvs_r == 8'h00) || (q_r[15:8] != 8'h00);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      cnt_r   <= 5'h00;
      last_r  <= 5'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (dv.start) begin
            state_r <= ST_RUN;
            cnt_r   <= 5'h01;
            last_r  <= (dv.divisor == 8'h00) ? udiv_pkg::CYC_ZERO - 5'h01 : udiv_pkg::CYC_FULL - 5'h01;
          end
        end
        ST_RUN: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == last_r) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r   <= 16'h0000;
      rem_r <= 8'h00;
      dvd_r <= 16'h0000;
      dvs_r <= 8'h00;
    end else if (state_r == ST_IDLE && dv.start) begin
      q_r   <= dv.dividend;
      rem_r <= 8'h00;
      dvd_r <= dv.dividend;
      dvs_r <= dv.divisor;
    end else if (state_r == ST_RUN && cnt_r <= udiv_pkg::ITER_N && dvs_r != 8'h00) begin
      // plain magnitude compare, no sign handling anywhere
      q_r   <= {q_r[14:0], take};
      rem_r <= take ? 8'(sh - {1'b0, dvs_r}) : sh[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_r   <= 1'b0;
      quot_o_r <= 8'h00;
      rem_o_r  <= 8'h00;
      fc_r     <= 1'b0;
      fz_r     <= 1'b0;
      fs_r     <= 1'b0;
      fv_r     <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (state_r == ST_RUN && cnt_r == last_r) begin
        done_r   <= 1'b1;
        // halves are just the low bits when overflowing
        quot_o_r <= q_r[7:0];
        rem_o_r  <= rem_r;
        fc_r     <= ovf && dvs_r != 8'h00 && q_r[15:9] == 7'h00 && q_r[8];
        fz_r     <= dvs_r == 8'h00 || q_r == 16'h0000;
        fs_r     <= q_r[7];
        fv_r     <= ovf;
      end
    end
  end

  assign dv.busy = state_r == ST_RUN;
  assign dv.done = done_r;
  assign dv.quot = quot_o_r;
  assign dv.rem  = rem_o_r;
  assign dv.fc   = fc_r;
  assign dv.fz   = fz_r;
  assign dv.fs   = fs_r;
  assign dv.fv   = fv_r;

  AST_QUOT: assert property (@(posedge aclk) disable iff (!aresetn)
    done_r && !fv_r |-> quot_o_r == 8'(dvd_r / {8'h00, dvs_r}))
    else $error("quotient wrong");
  AST_REM: assert property (@(posedge aclk) disable iff (!aresetn)
    done_r && dvs_r != 8'h00 |-> rem_o_r == 8'(dvd_r % {8'h00, dvs_r}))
    else $error("remainder wrong");
  AST_CARRY: assert property (@(posedge aclk) disable iff (!aresetn)
    done_r |-> fc_r == (dvs_r != 8'h00 && dvd_r / {8'h00, dvs_r} >= 16'h0100
                        && dvd_r / {8'h00, dvs_r} <= 16'h01FF))
    else $error("carry wrong");
  AST_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    done_r |-> fz_r == (dvs_r == 8'h00 || dvd_r < {8'h00, dvs_r}))
    else $error("zero flag wrong");
  AST_SIGN: assert property (@(posedge aclk) disable iff (!aresetn)
    done_r && dvs_r != 8'h00 |-> fs_r == (((dvd_r / {8'h00, dvs_r}) & 16'h0080) != 16'h0000))
    else $error("sign flag wrong");
  AST_OVF: assert property (@(posedge aclk) disable iff (!aresetn)
    done_r |-> fv_r == (dvs_r == 8'h00 || dvd_r / {8'h00, dvs_r} >= 16'h0100))
    else $error("overflow flag wrong");
  AST_TIME_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ST_IDLE && dv.start && dv.divisor == 8'h00 |-> ##1 (!done_r [*8]) ##1 !done_r ##1 done_r)
    else $error("zero divide not 10 cycles");
  AST_TIME_FULL: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ST_IDLE && dv.start && dv.divisor != 8'h00 |-> ##1 (!done_r [*8]) ##17 !done_r ##1 done_r)
    else $error("divide not 26 cycles");
endmodule
`default_nettype wire

// file: hw/udiv_top.sv
// unsigned 16 by 8 divide unit with axi4-lite register file
// assumes one axi4-lite master, 32-bit data, operands fetched by software
//
// Contract
// - The unit divides a 16-bit register-pair value by an 8-bit divisor.
// - The 8-bit quotient goes to the low (odd) half of the pair when the divide ends.
// - The 8-bit remainder goes to the high (even) half of the pair when the divide ends.
// - With a quotient of 256 or more the stored halves need not be correct; only flags tell.
// - Both operands are plain unsigned numbers with no sign handling.
// - Carry is set only with overflow and a quotient from 256 to 511, else cleared.
// - Zero is set when the divisor or the quotient is zero, else cleared.
// - Sign follows the top bit of the quotient.
// - Overflow is set for a quotient of 256 or more or a zero divisor, else cleared.
// - The decimal-adjust and half-carry flags keep their old values.
// - Opcodes 94, 95 and 96 select register, pointer or literal divisor; 10 cycles on zero, else 26.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module udiv_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // interrupt
  output logic                   irq
);
  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W below 8 cannot hold the register map");
  end

  udiv_if dv ();

  logic                   aw_hold_r;
  logic [7:0]             awaddr_r;
  logic                   w_hold_r;
  logic [31:0]            wdata_r;
  logic [3:0]             wstrb_r;
  logic                   bvalid_r;
  logic [1:0]             bresp_r;
  logic                   rvalid_r;
  logic [1:0]             rresp_r;
  logic [31:0]            rdata_r;
  logic                   wr_go;
  logic                   rd_go;
  logic [7:0]             wr_off;
  logic [7:0]             rd_off;
  logic                   wr_err;
  logic                   rd_err;
  logic [31:0]            rd_mux;
  logic                   start_r;
  logic                   busy_any;
  logic [7:0]             opc_r;
  udiv_pkg::udiv_mode_e   mode_r;
  logic                   opc_ok;
  logic [15:0]            dividend_r;
  logic [7:0]             divisor_r;
  logic [7:0]             flags_r;
  logic [15:0]            result_r;
  logic [1:0]             int_stat_r;
  logic [1:0]             int_mask_r;
  logic [1:0]             int_set;
  logic [1:0]             int_clr;
  logic                   ctrl_wr;

  // write channels are caught separately so either may arrive first
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign wr_go         = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_off        = {awaddr_r[7:2], 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr[7:0];
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end
  end

  always_comb begin
    case (wr_off)
      udiv_pkg::OFF_CTRL, udiv_pkg::OFF_DIVIDEND, udiv_pkg::OFF_DIVISOR, udiv_pkg::OFF_FLAGS,
      udiv_pkg::OFF_INT_STAT, udiv_pkg::OFF_INT_MASK: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= udiv_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_err ? udiv_pkg::RESP_SLVERR : udiv_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // read path: one cycle from address to data
  assign s_axi_arready = !rvalid_r;
  assign rd_go         = s_axi_arvalid && !rvalid_r;
  assign rd_off        = {s_axi_araddr[7:2], 2'h0};

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (rd_off)
      udiv_pkg::OFF_CTRL:     rd_mux = {24'h00_0000, opc_r};
      udiv_pkg::OFF_DIVIDEND: rd_mux = {16'h0000, dividend_r};
      udiv_pkg::OFF_DIVISOR:  rd_mux = {24'h00_0000, divisor_r};
      udiv_pkg::OFF_FLAGS:    rd_mux = {24'h00_0000, flags_r};
      udiv_pkg::OFF_RESULT:   rd_mux = {16'h0000, result_r};
      udiv_pkg::OFF_STATUS:   rd_mux = {28'h000_0000, mode_r, 1'b0, busy_any};
      udiv_pkg::OFF_INT_STAT: rd_mux = {30'h0000_0000, int_stat_r};
      udiv_pkg::OFF_INT_MASK: rd_mux = {30'h0000_0000, int_mask_r};
      default:                rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= udiv_pkg::RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_err ? udiv_pkg::RESP_SLVERR : udiv_pkg::RESP_OKAY;
      rdata_r  <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  // instruction launch
  assign busy_any = dv.busy || start_r;
  assign ctrl_wr  = wr_go && wr_off == udiv_pkg::OFF_CTRL && wstrb_r[0];
  assign opc_ok   = wdata_r[7:0] == udiv_pkg::OPC_PAIR || wdata_r[7:0] == udiv_pkg::OPC_PTR
                    || wdata_r[7:0] == udiv_pkg::OPC_LIT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_r <= 1'b0;
      opc_r   <= 8'h00;
      mode_r  <= udiv_pkg::udiv_no_mode;
    end else begin
      start_r <= 1'b0;
      if (ctrl_wr && opc_ok && !busy_any) begin
        start_r <= 1'b1;
        opc_r   <= wdata_r[7:0];
        // operand fetch sits outside; the mode is kept for software to see
        case (wdata_r[7:0])
          udiv_pkg::OPC_PAIR: mode_r <= udiv_pkg::register_pair_mode;
          udiv_pkg::OPC_PTR:  mode_r <= udiv_pkg::pointer_operand_mode;
          default:            mode_r <= udiv_pkg::literal_operand_mode;
        endcase
      end
    end
  end

  // operands frozen while a divide runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dividend_r <= 16'h0000;
      divisor_r  <= 8'h00;
    end else if (wr_go && !busy_any) begin
      if (wr_off == udiv_pkg::OFF_DIVIDEND && wstrb_r[0]) dividend_r[7:0] <= wdata_r[7:0];
      if (wr_off == udiv_pkg::OFF_DIVIDEND && wstrb_r[1]) dividend_r[15:8] <= wdata_r[15:8];
      if (wr_off == udiv_pkg::OFF_DIVISOR && wstrb_r[0]) divisor_r <= wdata_r[7:0];
    end
  end

  assign dv.start    = start_r;
  assign dv.dividend = dividend_r;
  assign dv.divisor  = divisor_r;

  // single commit point keeps a half-done result invisible
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r  <= udiv_pkg::RST_FLAGS;
      result_r <= udiv_pkg::RST_RESULT;
    end else if (dv.done) begin
      result_r              <= {dv.rem, dv.quot};
      flags_r[udiv_pkg::FLG_C] <= dv.fc;
      flags_r[udiv_pkg::FLG_Z] <= dv.fz;
      flags_r[udiv_pkg::FLG_S] <= dv.fs;
      flags_r[udiv_pkg::FLG_V] <= dv.fv;
    end else if (wr_go && !busy_any && wr_off == udiv_pkg::OFF_FLAGS && wstrb_r[0]) begin
      flags_r <= wdata_r[7:0];
    end
  end
  // d and h bits are only written by software, never by a commit

  // interrupts: set wins over a write-one clear
  always_comb begin
    int_set                     = 2'h0;
    int_set[udiv_pkg::INT_DONE] = dv.done;
    int_set[udiv_pkg::INT_BAD]  = ctrl_wr && (!opc_ok || busy_any);
    int_clr = (wr_go && wr_off == udiv_pkg::OFF_INT_STAT && wstrb_r[0]) ? wdata_r[1:0] : 2'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_r <= 2'h0;
      int_mask_r <= 2'h0;
    end else begin
      int_stat_r <= (int_stat_r & ~int_clr) | int_set;
      if (wr_go && wr_off == udiv_pkg::OFF_INT_MASK && wstrb_r[0]) int_mask_r <= wdata_r[1:0];
    end
  end

  assign irq = |(int_stat_r & int_mask_r);

  udiv_core u_core (
    .aclk    (aclk),
    .aresetn (aresetn),
    .dv      (dv.core)
  );

  AST_DH_KEPT: assert property (@(posedge aclk) disable iff (!aresetn)
    dv.done |=> flags_r[3:0] == $past(flags_r[3:0]))
    else $error("d or h flag changed by divide");
  AST_COMMIT: assert property (@(posedge aclk) disable iff (!aresetn)
    dv.busy |=> $stable(result_r) && $stable(flags_r))
    else $error("result changed before commit");
  AST_LAUNCH: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_wr && opc_ok && !busy_any |=> start_r ##1 dv.busy)
    else $error("valid opcode did not start divide");

  // register side: results move only at the commit, launches follow the opcode
  AST_RES_COMMIT: assert property (@(posedge aclk) disable iff (!aresetn)
    dv.done |=> result_r == $past({dv.rem, dv.quot}))
    else $error("result not committed with done");
  AST_FLG_COMMIT: assert property (@(posedge aclk) disable iff (!aresetn)
    dv.done |=> flags_r[udiv_pkg::FLG_C] == $past(dv.fc) && flags_r[udiv_pkg::FLG_Z] == $past(dv.fz)
                && flags_r[udiv_pkg::FLG_S] == $past(dv.fs) && flags_r[udiv_pkg::FLG_V] == $past(dv.fv))
    else $error("flags not committed with done");
  AST_RES_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
    !dv.done |=> $stable(result_r))
    else $error("result changed outside commit");
  AST_FLG_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
    !dv.done && !(wr_go && wr_off == udiv_pkg::OFF_FLAGS) |=> $stable(flags_r))
    else $error("flags changed outside commit or write");
  AST_OPND_FROZEN: assert property (@(posedge aclk) disable iff (!aresetn)
    busy_any |=> $stable(dividend_r) && $stable(divisor_r))
    else $error("operand changed during divide");
  AST_DONE_INT: assert property (@(posedge aclk) disable iff (!aresetn)
    dv.done |=> int_stat_r[udiv_pkg::INT_DONE])
    else $error("done not flagged");
  AST_BAD_CMD: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_wr && (busy_any || !opc_ok) |=> int_stat_r[udiv_pkg::INT_BAD] && !start_r)
    else $error("refused command not flagged");
  AST_LAUNCH_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    start_r |-> $past(ctrl_wr && opc_ok && !busy_any))
    else $error("start without accepted opcode");
  AST_GO_PAIR: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_wr && !busy_any && wdata_r[7:0] == udiv_pkg::OPC_PAIR
    |=> start_r && opc_r == udiv_pkg::OPC_PAIR && mode_r == udiv_pkg::register_pair_mode)
    else $error("pair opcode not launched");
  AST_GO_PTR: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_wr && !busy_any && wdata_r[7:0] == udiv_pkg::OPC_PTR
    |=> start_r && opc_r == udiv_pkg::OPC_PTR && mode_r == udiv_pkg::pointer_operand_mode)
    else $error("pointer opcode not launched");
  AST_GO_LIT: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_wr && !busy_any && wdata_r[7:0] == udiv_pkg::OPC_LIT
    |=> start_r && opc_r == udiv_pkg::OPC_LIT && mode_r == udiv_pkg::literal_operand_mode)
    else $error("literal opcode not launched");
endmodule
`default_nettype wire

// file: verification/udiv_seq_model.sv
// axi4-lite master standing in for the cpu sequencer and register file
// assumes the udiv_top slave and one transfer of each kind at a time
`timescale 1ns/1ns
`default_nettype none
module udiv_seq_model (
  // clock
  input  wire logic        aclk,
  // write channels
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  output logic             bready,
  // read channels
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic        rvalid,
  output logic             rready
);
  // response readies stay high: legal, and no same-step toggles between transfers
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
  endtask
endmodule
`default_nettype wire

// file: verification/unsigned_16by8_divider_tb.sv
// self-checking bench for the unsigned 16 by 8 divide unit
// assumes udiv_top with default address width, seq model as bus master
`timescale 1ns/1ns
`default_nettype none
module unsigned_16by8_divider_tb;
  typedef struct packed {logic [31:0] d; logic [1:0] resp;} udiv_note_s;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        irq;
  udiv_note_s  notes[$];
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  udiv_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  udiv_seq_model seq (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // results are compared where they appear, against the oldest note
  always @(posedge aclk) begin
    udiv_note_s n;
    if (aresetn && ((bvalid && bready) || (rvalid && rready))) begin
      if (notes.size() == 0) begin
        check(32'h0000_DEAD, 32'h0000_0000);
      end else begin
        n = notes.pop_front();
        if (rvalid) check(rdata, n.d);
        check({30'h0, bvalid ? bresp : rresp}, {30'h0, n.resp});
      end
    end
  end
  task automatic wexp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = udiv_pkg::RESP_OKAY);
    notes.push_back('{32'h0, r});
    seq.wr(a, d);
  endtask
  task automatic rexp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = udiv_pkg::RESP_OKAY);
    notes.push_back('{d, r});
    seq.rd(a);
  endtask
  task automatic do_div(input logic [7:0] op, input logic [15:0] dvd, input logic [7:0] dvs,
                        input logic [7:0] fpre, input logic poke);
    logic [15:0] q;
    logic [7:0]  r;
    logic [7:0]  f;
    logic        ov;
    int          t0;
    q = (dvs == 8'h00) ? 16'h0000 : dvd / dvs;
    r = (dvs == 8'h00) ? 8'h00 : 8'(dvd % dvs);
    ov = (dvs == 8'h00) || (q > 16'h00FF);
    f = fpre & 8'h0F;
    f[udiv_pkg::FLG_C] = (dvs != 8'h00) && (q > 16'h00FF) && (q < 16'h0200);
    f[udiv_pkg::FLG_Z] = (dvs == 8'h00) || (q == 16'h0000);
    f[udiv_pkg::FLG_S] = (dvs == 8'h00) ? dvd[7] : q[7];
    f[udiv_pkg::FLG_V] = ov;
    wexp(udiv_pkg::OFF_FLAGS, {24'h0, fpre});
    wexp(udiv_pkg::OFF_DIVIDEND, {16'h0, dvd});
    wexp(udiv_pkg::OFF_DIVISOR, {24'h0, dvs});
    wexp(udiv_pkg::OFF_INT_STAT, 32'h0000_0003);
    wexp(udiv_pkg::OFF_CTRL, {24'h0, op});
    t0 = cyc;
    if (poke) begin
      rexp(udiv_pkg::OFF_STATUS, {28'h0, 2'(op - udiv_pkg::OPC_PAIR), 2'b01});
      wexp(udiv_pkg::OFF_CTRL, {24'h0, op});
      wexp(udiv_pkg::OFF_DIVIDEND, 32'h0000_FFFF);
      rexp(udiv_pkg::OFF_DIVIDEND, {16'h0, dvd});
    end
    do @(posedge aclk); while (irq !== 1'b1 && cyc - t0 < 200);
    check(32'(cyc - t0), (dvs == 8'h00) ? 32'(udiv_pkg::CYC_ZERO) + 1 : 32'(udiv_pkg::CYC_FULL) + 1);
    rexp(udiv_pkg::OFF_STATUS, {28'h0, 2'(op - udiv_pkg::OPC_PAIR), 2'b00});
    // overflowed halves are left unchecked on purpose
    if (!ov) rexp(udiv_pkg::OFF_RESULT, {16'h0, r, q[7:0]});
    rexp(udiv_pkg::OFF_FLAGS, {24'h0, f});
    rexp(udiv_pkg::OFF_INT_STAT, poke ? 32'h0000_0003 : 32'h0000_0001);
    rexp(udiv_pkg::OFF_CTRL, {24'h0, op});
  endtask
  initial begin
    #(40 * 30000);
    n_errors++;
    conclude();
  end
  initial begin
    logic [7:0]  dvs;
    logic [15:0] dvd;
    aresetn = 1'b0;
    void'($urandom(32'h4442));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rexp(udiv_pkg::OFF_FLAGS, 32'h0);
    rexp(udiv_pkg::OFF_RESULT, 32'h0);
    rexp(udiv_pkg::OFF_STATUS, 32'h0000_000C);
    rexp(udiv_pkg::OFF_INT_MASK, 32'h0);
    rexp(8'h20, 32'h0, udiv_pkg::RESP_SLVERR);
    wexp(udiv_pkg::OFF_RESULT, 32'h0000_1234, udiv_pkg::RESP_SLVERR);
    // bad command raises, mask hides, write-one clears
    wexp(udiv_pkg::OFF_INT_MASK, 32'h2);
    wexp(udiv_pkg::OFF_CTRL, 32'h0000_0042);
    check({31'h0, irq}, 32'h1);
    wexp(udiv_pkg::OFF_INT_MASK, 32'h0);
    check({31'h0, irq}, 32'h0);
    wexp(udiv_pkg::OFF_INT_MASK, 32'h2);
    check({31'h0, irq}, 32'h1);
    wexp(udiv_pkg::OFF_INT_STAT, 32'h2);
    check({31'h0, irq}, 32'h0);
    rexp(udiv_pkg::OFF_INT_STAT, 32'h0);
    wexp(udiv_pkg::OFF_INT_MASK, 32'h1);
    do_div(udiv_pkg::OPC_PAIR, 16'h1003, 8'h40, 8'h00, 1'b0);
    do_div(udiv_pkg::OPC_PTR, 16'h1003, 8'h80, 8'hFF, 1'b0);
    do_div(udiv_pkg::OPC_LIT, 16'h1003, 8'h20, 8'h0C, 1'b0);
    do_div(udiv_pkg::OPC_PAIR, 16'h1234, 8'h00, 8'h03, 1'b0);
    do_div(udiv_pkg::OPC_PTR, 16'h0005, 8'h10, 8'hF0, 1'b0);
    do_div(udiv_pkg::OPC_LIT, 16'hFFFF, 8'h80, 8'h00, 1'b0);
    do_div(udiv_pkg::OPC_PAIR, 16'h0100, 8'h01, 8'h00, 1'b0);
    do_div(udiv_pkg::OPC_PTR, 16'hFFFF, 8'h01, 8'h00, 1'b0);
    do_div(udiv_pkg::OPC_LIT, 16'h00FF, 8'h01, 8'h00, 1'b0);
    do_div(udiv_pkg::OPC_PAIR, 16'hFEFF, 8'hFF, 8'h00, 1'b1);
    for (int i = 0; i < 8; i++) begin
      dvs = 8'($urandom_range(255, 1));
      dvd = 16'($urandom_range(32'(dvs) * 256 - 1, 0));
      do_div(udiv_pkg::OPC_PAIR + 8'($urandom_range(2, 0)), dvd, dvs, 8'($urandom_range(255, 0)), 1'b0);
    end
    conclude();
  end
endmodule
`default_nettype wire
